// File: design/aias_top.sv
// Summary of operation
// RQ1: the average may span a configurable number of processing cycles, at most 25.
// RQ2: in multi-cycle averaging every contributing cycle uses all 32 scans.
// RQ3: each extra averaged cycle adds one 4 ms cycle to the response time.
// RQ4: reduced-scan mode averages up to 32 chosen scans in one cycle only.
// RQ5: status bits 16 to 31 carry the measured value at every refresh while hide is clear.
// RQ6: with hide set, status bits 16 to 31 read constant ones.
// RQ7: seven signal-range bits encode the current signal range.
// RQ8: enable is one only with valid sensors, no discrepancy and value in process range.
// RQ9: sensor status is one only with valid sensors and no discrepancy.
// RQ10: the controller drives four process-range select bits.
// RQ11: diagnostic status bits refresh every 200 ms, apart from process data.
// RQ12: the controller combines sensor status with a reset so enable cannot restart alone.
// RQ13: by default 32 scans are averaged within each 4 ms cycle.
// RQ14: an invalid sensor value reports signal range number zero.
// RQ15: a fixed cycle tick sequences all work and reset clears accumulators and outputs.
//
// Purpose: averaging, range evaluation and status reporting of an analog input
// Assumes: sample, sensValid and discErr synchronous to clk_sys
// Notes: classic Wishbone slave, one wait state per access
`include "aias_consts.svh"
`default_nettype none
module aias_top
#(
  parameter int CYCLE_CLKS = `AIAS_CYCLE_CLKS,
  parameter int STAT_CLKS = `AIAS_STAT_CLKS,
  parameter int PROC_RANGES = 16
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // front end
  input wire logic [15:0] sample,
  input wire logic sensValid,
  input wire logic discErr,
  // controller logic
  input wire logic [3:0] procSel,
  output logic enable_q,
  output logic sensorOk_q,
  output logic [6:0] sigRange_q,
  output logic [31:0] statusWord_q,
  output logic irq_q,
  // wishbone
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR_q,
  output logic wbAck_q
);
  import aias_pkg::*;
  localparam int SCAN_CLKS = CYCLE_CLKS / `AIAS_FULL_SCANS;
  // three clocks at least between status ticks, else the tick spacing check cannot hold
  if (CYCLE_CLKS % 32 != 0 || SCAN_CLKS < 64 || STAT_CLKS < 3 || PROC_RANGES != 16)
  begin : gBadParam
    $error("aias_top: unsupported parameters");
  end

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      if (sel[i])
        old[8*i +: 8] = nw[8*i +: 8];
    return old;
  endfunction

  function automatic logic [6:0] encodeRange(input aias_coding_t cod, input logic [3:0] num);
    logic [6:0] res;
    res = 7'h00;
    if (num != 4'h0)
      unique case (cod)
        CODE_BIN: res = {3'h0, num};
        CODE_ONEHOT: res = 7'h01 << (num - 4'd1);
        CODE_LEVEL: res = 7'h7F >> (4'd7 - num);
        CODE_INVLEVEL: res = ~(7'h7F >> (4'd7 - num));
      endcase
    return res;
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] srLim_q [`AIAS_SR_THRESH];
  logic [31:0] procLim_q [PROC_RANGES];
  logic [2:0] irqStat_q, irqEn_q;
  logic [31:0] scanCnt_q, statCnt_q;
  logic scanTick_q, statTick_q;
  logic [15:0] measVal_q;
  logic [3:0] rangeNum_q;
  logic loOk_q, hiOk_q;
  logic [15:0] avgValue;
  logic avgOk, avgDone;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire req = wbCyc && wbStb && !wbAck_q;
  wire wr = req && wbWe;
  wire alignedAdr = wbAdr[1:0] == 2'b00;
  wire hitCtrl = wbAdr == `AIAS_ADDR_CTRL;
  wire hitClr = wbAdr == `AIAS_ADDR_ICLR;
  wire hitIen = wbAdr == `AIAS_ADDR_IEN;
  wire [2:0] srIdx = wbAdr[4:2];
  wire hitSr = wbAdr[7:5] == 3'b001 && alignedAdr && srIdx < 3'd6;
  wire [3:0] plIdx = wbAdr[5:2];
  wire hitPl = wbAdr[7:6] == 2'b01 && alignedAdr;
  wire [2:0] irqClr = (wr && hitClr) ? wbDatW[2:0] & {3{wbSel[0]}} : 3'h0;

  // ----------------------------------------
  // configuration with clamping
  // ----------------------------------------
  wire [4:0] rawCycles = ctrl_q[`AIAS_CTRL_CYC_LSB +: 5];
  wire reducedEn = ctrl_q[`AIAS_CTRL_RED_BIT];
  wire [5:0] rawScans = ctrl_q[`AIAS_CTRL_SCN_LSB +: 6];
  wire hideMeas = ctrl_q[`AIAS_CTRL_HIDE_BIT];
  wire aias_coding_t coding = aias_coding_t'(ctrl_q[`AIAS_CTRL_COD_LSB +: 2]);
  wire [4:0] clampCycles = rawCycles == 5'd0 ? 5'd1 :
                           (rawCycles > 5'd25 ? 5'd25 : rawCycles); // [RQ1]
  wire [5:0] clampScans = rawScans == 6'd0 ? 6'd1 :
                          (rawScans > 6'd32 ? 6'd32 : rawScans);
  wire [4:0] effCycles = reducedEn ? 5'd1 : clampCycles; // [RQ4] [RQ3]
  wire [5:0] effScans = reducedEn ? clampScans : 6'd32; // [RQ2] [RQ13]
  wire cfgValid = rawCycles >= 5'd1 && rawCycles <= 5'd25 && rawScans >= 6'd1 &&
                  rawScans <= 6'd32;

  // ----------------------------------------
  // range evaluation
  // ----------------------------------------
  logic [`AIAS_SR_THRESH-1:0] thrHit;
  genvar g;
  generate
    for (g = 0; g < `AIAS_SR_THRESH; g++)
    begin : gThr
      assign thrHit[g] = avgValue >= srLim_q[g][15:0];
    end
  endgenerate
  wire [3:0] hitCount = 4'(thrHit[0]) + 4'(thrHit[1]) + 4'(thrHit[2]) + 4'(thrHit[3]) +
                        4'(thrHit[4]) + 4'(thrHit[5]);
  wire [3:0] newRange = avgOk ? hitCount + 4'd1 : 4'd0; // [RQ14]
  wire [31:0] selLim = procLim_q[procSel]; // [RQ10]
  wire loOk = avgValue >= selLim[15:0];
  wire hiOk = avgValue <= selLim[31:16];
  wire newEnable = avgOk && loOk && hiOk; // [RQ8]
  wire [2:0] events = {avgDone & ~avgOk, avgDone & enable_q & ~newEnable, avgDone};
  wire [2:0] irqStatD = (irqStat_q & ~irqClr) | events;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] measWord = {sensorOk_q, enable_q, 3'h0, sigRange_q, rangeNum_q, measVal_q};
  wire [31:0] rdData = hitCtrl ? ctrl_q :
                       wbAdr == `AIAS_ADDR_ISTAT ? {29'h0, irqStat_q} :
                       hitIen ? {29'h0, irqEn_q} :
                       wbAdr == `AIAS_ADDR_MEAS ? measWord :
                       wbAdr == `AIAS_ADDR_DIAG ? statusWord_q :
                       hitSr ? srLim_q[srIdx] :
                       hitPl ? procLim_q[plIdx] : 32'h0000_0000;

  // ----------------------------------------
  // bus and register writes
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wbAck_q <= 1'b0;
      wbDatR_q <= 32'h0000_0000;
      ctrl_q <= `AIAS_CTRL_RST;
      irqEn_q <= 3'h0;
    end
    else
    begin
      wbAck_q <= req;
      wbDatR_q <= req && !wbWe ? rdData : 32'h0000_0000;
      if (wr && hitCtrl)
        ctrl_q <= mergeBytes(ctrl_q, wbDatW, wbSel);
      if (wr && hitIen && wbSel[0])
        irqEn_q <= wbDatW[2:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < `AIAS_SR_THRESH; i++)
      if (reset)
        srLim_q[i] <= `AIAS_SRLIM_RST;
      else if (wr && hitSr && srIdx == 3'(i))
        srLim_q[i] <= mergeBytes(srLim_q[i], wbDatW, wbSel);
    for (int i = 0; i < PROC_RANGES; i++)
      if (reset)
        procLim_q[i] <= `AIAS_PLIM_RST;
      else if (wr && hitPl && plIdx == 4'(i))
        procLim_q[i] <= mergeBytes(procLim_q[i], wbDatW, wbSel);
  end

  // ----------------------------------------
  // cycle ticks
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      scanCnt_q <= 32'h0000_0000;
      scanTick_q <= 1'b0;
      statCnt_q <= 32'h0000_0000;
      statTick_q <= 1'b0;
    end
    else
    begin
      scanTick_q <= scanCnt_q == 32'(SCAN_CLKS - 1); // [RQ15]
      scanCnt_q <= scanCnt_q == 32'(SCAN_CLKS - 1) ? 32'h0 : scanCnt_q + 32'd1;
      statTick_q <= statCnt_q == 32'(STAT_CLKS - 1); // [RQ11]
      statCnt_q <= statCnt_q == 32'(STAT_CLKS - 1) ? 32'h0 : statCnt_q + 32'd1;
    end
  end

  aias_averager uAvg
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .scanTick(scanTick_q),
    .sample(sample),
    .sampleOk(sensValid & ~discErr), // [RQ9]
    .nCycles(effCycles),
    .nScans(effScans),
    .avgValue_q(avgValue),
    .avgOk_q(avgOk),
    .avgDone_q(avgDone)
  );

  // ----------------------------------------
  // process outputs and status
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      enable_q <= 1'b0;
      sensorOk_q <= 1'b0;
      sigRange_q <= 7'h00;
      rangeNum_q <= 4'h0;
      measVal_q <= 16'h0000;
      loOk_q <= 1'b0;
      hiOk_q <= 1'b0;
      statusWord_q <= 32'h0000_0000;
      irqStat_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      irqStat_q <= irqStatD;
      irq_q <= |(irqStatD & irqEn_q);
      if (avgDone)
      begin
        enable_q <= newEnable; // [RQ8]
        sensorOk_q <= avgOk; // [RQ9]
        sigRange_q <= encodeRange(coding, newRange); // [RQ7] [RQ14]
        rangeNum_q <= newRange;
        measVal_q <= avgValue;
        loOk_q <= loOk;
        hiOk_q <= hiOk;
      end
      // diagnostics lag process data by up to one refresh period
      if (statTick_q)
        statusWord_q <= {hideMeas ? 16'hFFFF : measVal_q, // [RQ5] [RQ6]
                         11'h000, enable_q, hiOk_q, loOk_q, sensorOk_q, cfgValid}; // [RQ11]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  cycle_clamp_a: assert property (effCycles >= 5'd1 && effCycles <= 5'd25) // [RQ1]
    else $error("averaged cycle count out of range");
  full_scans_a: assert property (!reducedEn |-> effScans == 6'd32) // [RQ2]
    else $error("multi-cycle averaging not using 32 scans");
  reduced_single_a: assert property (reducedEn |-> effCycles == 5'd1 && effScans <= 6'd32) // [RQ4]
    else $error("reduced scans did not force one cycle");
  meas_bits_a: assert property (statTick_q && !hideMeas |=> // [RQ5]
                                statusWord_q[31:16] == $past(measVal_q))
    else $error("status upper half differs from measured value");
  hide_bits_a: assert property (statTick_q && hideMeas |=> statusWord_q[31:16] == 16'hFFFF) // [RQ6]
    else $error("hidden status bits not all ones");
  enable_cause_a: assert property (avgDone |=> enable_q == ($past(avgOk) && $past(loOk) && // [RQ8]
                                   $past(hiOk)) && (enable_q -> sensorOk_q))
    else $error("enable not tied to validity and process range");
  sensor_status_a: assert property (avgDone |=> sensorOk_q == $past(avgOk)) // [RQ9]
    else $error("sensor status does not follow validity");
  range_zero_a: assert property (!sensorOk_q |-> sigRange_q == 7'h00) // [RQ14]
    else $error("invalid value reports a nonzero signal range");
  onehot_range_a: assert property (coding == CODE_ONEHOT && avgDone && avgOk |=> // [RQ7]
                                   $onehot(sigRange_q))
    else $error("one-of-n range code not one-hot");
  stat_period_a: assert property (statTick_q |=> !statTick_q [*2]) // [RQ11]
    else $error("status refresh ticks too close");
  scan_period_a: assert property (scanTick_q |=> !scanTick_q [*8]) // [RQ15]
    else $error("scan ticks too close");
  irq_level_a: assert property (##1 irq_q == |($past(irqStatD) & $past(irqEn_q)))
    else $error("interrupt output disagrees with enabled status");
endmodule // aias_top
`default_nettype wire

// File: design/aias_consts.svh
// Purpose: constants of the analog input averaging and status block
// Assumes: 250 MHz system clock
// Notes: offsets are byte addresses on the register bus
`ifndef AIAS_CONSTS_SVH
`define AIAS_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AIAS_ADDR_CTRL 8'h00
`define AIAS_ADDR_ISTAT 8'h04
`define AIAS_ADDR_ICLR 8'h08
`define AIAS_ADDR_IEN 8'h0C
`define AIAS_ADDR_MEAS 8'h10
`define AIAS_ADDR_DIAG 8'h14
`define AIAS_ADDR_SRLIM 8'h20
`define AIAS_ADDR_PLIM 8'h40

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define AIAS_CTRL_CYC_LSB 0
`define AIAS_CTRL_RED_BIT 5
`define AIAS_CTRL_SCN_LSB 6
`define AIAS_CTRL_HIDE_BIT 12
`define AIAS_CTRL_COD_LSB 13
`define AIAS_CTRL_RST 32'h0000_0801
`define AIAS_SRLIM_RST 32'h0000_FFFF
`define AIAS_PLIM_RST 32'hFFFF_0000
`define AIAS_IRQ_NEW 0
`define AIAS_IRQ_ENLOST 1
`define AIAS_IRQ_SENSERR 2

// ----------------------------------------
// counts and timing
// ----------------------------------------
`define AIAS_MAX_CYCLES 25
`define AIAS_FULL_SCANS 32
`define AIAS_SR_THRESH 6
`define AIAS_CLK_MHZ 250
`define AIAS_CYCLE_TIME_US 4000
`define AIAS_STAT_TIME_MS 200
`define AIAS_CYCLE_CLKS (`AIAS_CYCLE_TIME_US * `AIAS_CLK_MHZ)
`define AIAS_STAT_CLKS (`AIAS_STAT_TIME_MS * 1000 * `AIAS_CLK_MHZ)

`endif

// File: design/aias_pkg.sv
// Purpose: types of the analog input averaging and status block
// Assumes: nothing
// Notes: constants live in aias_consts.svh
`default_nettype none
package aias_pkg;
  typedef enum logic [1:0] {
    CODE_BIN = 2'b00,
    CODE_ONEHOT = 2'b01,
    CODE_LEVEL = 2'b10,
    CODE_INVLEVEL = 2'b11
  } aias_coding_t;
  typedef enum logic {
    AV_IDLE = 1'b0,
    AV_DIV = 1'b1
  } aias_avstate_t;
endpackage
`default_nettype wire

// File: design/aias_averager.sv
// Purpose: scan accumulation over one or more cycles and division to the average
// Assumes: scanTick every 1/32 of a processing cycle, nCycles 1..25, nScans 1..32
// Notes: divider needs 26 clocks, far less than one scan period
`include "aias_consts.svh"
`default_nettype none
module aias_averager
#(
  parameter int MAX_CYCLES = `AIAS_MAX_CYCLES,
  parameter int SCANS = `AIAS_FULL_SCANS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // scans
  input wire logic scanTick,
  input wire logic [15:0] sample,
  input wire logic sampleOk,
  // setup
  input wire logic [4:0] nCycles,
  input wire logic [5:0] nScans,
  // result
  output logic [15:0] avgValue_q,
  output logic avgOk_q,
  output logic avgDone_q
);
  import aias_pkg::*;
  if (MAX_CYCLES > 25 || SCANS != 32)
  begin : gBadSize
    $error("aias_averager: unsupported sizes");
  end

  aias_avstate_t state_q;
  logic [4:0] scanIdx_q, cycIdx_q, bitCnt_q;
  logic [25:0] sum_q, dvd_q;
  logic [11:0] rem_q;
  logic [10:0] divisor_q;
  logic ok_q, okHold_q;

  // ----------------------------------------
  // accumulation
  // ----------------------------------------
  wire scanUse = {1'b0, scanIdx_q} < nScans; // [RQ4]
  wire lastScan = scanTick && scanIdx_q == 5'd31; // [RQ2] [RQ13]
  wire blockEnd = lastScan && cycIdx_q >= nCycles - 5'd1; // [RQ1] [RQ3]
  wire [25:0] sumNext = sum_q + (scanUse ? {10'h000, sample} : 26'h0000000);
  wire okNext = ok_q & (sampleOk | ~scanUse);
  wire [11:0] remShift = {rem_q[10:0], dvd_q[25]};
  wire remGe = remShift >= {1'b0, divisor_q};
  wire [10:0] product = 11'(nScans * nCycles);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      scanIdx_q <= 5'h00;
      cycIdx_q <= 5'h00;
      sum_q <= 26'h0000000;
      ok_q <= 1'b1;
    end
    else if (scanTick)
    begin
      scanIdx_q <= scanIdx_q + 5'd1;
      cycIdx_q <= blockEnd ? 5'h00 : (lastScan ? cycIdx_q + 5'd1 : cycIdx_q); // [RQ3]
      sum_q <= blockEnd ? 26'h0000000 : sumNext;
      ok_q <= blockEnd ? 1'b1 : okNext;
    end
  end

  // ----------------------------------------
  // restoring divider
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= AV_IDLE;
      dvd_q <= 26'h0000000;
      rem_q <= 12'h000;
      divisor_q <= 11'h001;
      bitCnt_q <= 5'h00;
      okHold_q <= 1'b0;
      avgValue_q <= 16'h0000;
      avgOk_q <= 1'b0;
      avgDone_q <= 1'b0;
    end
    else
    begin
      avgDone_q <= 1'b0;
      unique case (state_q)
        AV_IDLE:
        begin
          if (blockEnd)
          begin
            state_q <= AV_DIV;
            dvd_q <= sumNext;
            rem_q <= 12'h000;
            divisor_q <= product;
            bitCnt_q <= 5'd25;
            okHold_q <= okNext;
          end
        end
        AV_DIV:
        begin
          dvd_q <= {dvd_q[24:0], remGe};
          rem_q <= remGe ? remShift - {1'b0, divisor_q} : remShift;
          bitCnt_q <= bitCnt_q - 5'd1;
          if (bitCnt_q == 5'd0)
          begin
            state_q <= AV_IDLE;
            avgValue_q <= {dvd_q[14:0], remGe};
            avgOk_q <= okHold_q;
            avgDone_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence blockClose;
    blockEnd && state_q == AV_IDLE;
  endsequence
  sequence resultOut;
    ##27 avgDone_q;
  endsequence
  block_result_a: assert property (blockClose |-> resultOut) // [RQ3]
    else $error("average not produced 27 clocks after block end");
  one_cycle_a: assert property (lastScan && nCycles == 5'd1 |-> blockEnd) // [RQ4]
    else $error("single cycle setting did not close block");
endmodule // aias_averager
`default_nettype wire

// File: tb/aias_ctrl_model.sv
// Purpose: controller-side model of the logic program facing the block
// Assumes: same clock as the block
// Notes: restart latch needs an explicit request after any fault
`default_nettype none
module aias_ctrl_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // program side
  input wire logic [3:0] wantSel,
  input wire logic restartReq,
  output logic runOk_q,
  // block side
  input wire logic enable_q,
  input wire logic sensorOk_q,
  output logic [3:0] procSel_q
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      procSel_q <= 4'h0;
      runOk_q <= 1'b0;
    end
    else
    begin
      procSel_q <= wantSel;
      // a returning enable alone must not restart the machine
      if (!sensorOk_q || !enable_q)
        runOk_q <= 1'b0;
      else if (restartReq)
        runOk_q <= 1'b1;
    end
  end
endmodule // aias_ctrl_model
`default_nettype wire

// File: tb/aias_top_bench.sv
// Purpose: self-checking bench of the averaging and status block
// Assumes: shortened cycle and status periods
// Notes: constant samples per block, so block phase does not matter
`include "aias_consts.svh"
`default_nettype none
module aias_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 2048;
  localparam int STAT = 500;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] sample = 16'h0000;
  logic sensValid = 1'b1;
  logic discErr = 1'b0;
  logic [3:0] wantSel = 4'h0;
  logic restartReq = 1'b0;
  logic [3:0] procSel;
  logic enable_q, sensorOk_q, irq_q, wbAck_q, runOk_q;
  logic [6:0] sigRange_q;
  logic [31:0] statusWord_q, wbDatR_q, rd;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0000_0000;
  integer seed = 32'h17572707;
  int bad_count = 0;
  int comparisons = 0;

  always #2 clk_sys = ~clk_sys;

  aias_top #(.CYCLE_CLKS(CYC), .STAT_CLKS(STAT)) DUT (.clk_sys(clk_sys), .reset(reset),
    .sample(sample), .sensValid(sensValid), .discErr(discErr), .procSel(procSel),
    .enable_q(enable_q), .sensorOk_q(sensorOk_q), .sigRange_q(sigRange_q),
    .statusWord_q(statusWord_q), .irq_q(irq_q), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR_q(wbDatR_q), .wbAck_q(wbAck_q));

  aias_ctrl_model ctrl (.clk_sys(clk_sys), .reset(reset), .wantSel(wantSel),
    .restartReq(restartReq), .runOk_q(runOk_q), .enable_q(enable_q), .sensorOk_q(sensorOk_q),
    .procSel_q(procSel));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatW <= dat;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wbAck_q !== 1'b1 && n < 20);
    check({31'h0, wbAck_q}, 32'h1);
    rd = wbDatR_q;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  // clear the new-average flag, then wait for the next block result
  task automatic wait_avg(output time t);
    int n;
    wb(1'b1, `AIAS_ADDR_ICLR, 32'h1);
    n = 0;
    @(posedge clk_sys);
    while (irq_q !== 1'b1 && n < 8 * CYC)
    begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, irq_q}, 32'h1);
    t = $time;
  endtask

  function automatic logic [3:0] exp_num(input logic [15:0] v);
    exp_num = 4'h1;
    for (int k = 1; k <= 6; k++)
      if (v >= 16'(k * 8192))
        exp_num = exp_num + 4'h1;
  endfunction

  function automatic logic [6:0] exp_code(input logic [3:0] n, input logic [1:0] c);
    logic [6:0] lv;
    lv = 7'((8'h01 << n) - 8'h01);
    if (n == 4'h0)
      exp_code = 7'h00;
    else if (c == 2'h0)
      exp_code = {3'h0, n};
    else if (c == 2'h1)
      exp_code = 7'(8'h01 << (n - 4'h1));
    else if (c == 2'h2)
      exp_code = lv;
    else
      exp_code = ~lv;
  endfunction

  task automatic give_verdict();
    $display("checks %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    time t0, t1;
    logic [15:0] v;
    logic inR;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    wb(1'b0, `AIAS_ADDR_CTRL, 32'h0);
    check(rd, `AIAS_CTRL_RST);
    wb(1'b0, `AIAS_ADDR_SRLIM, 32'h0);
    check(rd, `AIAS_SRLIM_RST);
    wb(1'b0, `AIAS_ADDR_PLIM, 32'h0);
    check(rd, `AIAS_PLIM_RST);
    wb(1'b0, `AIAS_ADDR_IEN, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    // cycle count above the limit: raw field kept, clamped where used, flagged invalid
    wb(1'b1, `AIAS_ADDR_CTRL, 32'h0000_081F);
    wb(1'b0, `AIAS_ADDR_CTRL, 32'h0);
    check({27'h0, rd[4:0]}, 32'd31);
    repeat (STAT + 4) @(posedge clk_sys);
    check(statusWord_q[0], 1'b0);
    for (int k = 0; k < 6; k++)
      wb(1'b1, 8'(`AIAS_ADDR_SRLIM + 4 * k), 32'((k + 1) * 8192));
    wb(1'b1, 8'(`AIAS_ADDR_PLIM + 20), 32'h8000_4000);
    wb(1'b1, `AIAS_ADDR_IEN, 32'h1);
    // every coding, with threshold hits and an out-of-range case
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($random(seed));
      if (i == 1)
        v = 16'h6000;
      if (i == 2)
        v = 16'hFFFF;
      if (i == 3)
        v = 16'h2000;
      sample <= v;
      wantSel <= i[0] ? 4'h5 : 4'h0;
      inR = !i[0] || (v >= 16'h4000 && v <= 16'h8000);
      wb(1'b1, `AIAS_ADDR_CTRL, 32'h801 | (i << 13));
      wait_avg(t0);
      wait_avg(t1);
      check(32'(t1 - t0), CYC * 4);
      check(sigRange_q, exp_code(exp_num(v), 2'(i)));
      check(enable_q, inR);
      check(sensorOk_q, 1'b1);
      wb(1'b0, `AIAS_ADDR_MEAS, 32'h0);
      check(rd, {1'b1, inR, 3'h0, exp_code(exp_num(v), 2'(i)), exp_num(v), v});
    end
    repeat (STAT + 4) @(posedge clk_sys);
    check(statusWord_q[31:16], v);
    check(statusWord_q[4:0], 5'h0B);
    wb(1'b1, `AIAS_ADDR_CTRL, 32'h0000_1801);
    repeat (2 * STAT + 4) @(posedge clk_sys);
    check(statusWord_q[31:16], 16'hFFFF);
    // discrepancy, then invalid sensor
    for (int j = 0; j < 2; j++)
    begin
      discErr <= (j == 0);
      sensValid <= (j != 0) ? 1'b0 : 1'b1;
      wait_avg(t0);
      wait_avg(t0);
      check(sensorOk_q, 1'b0);
      check(enable_q, 1'b0);
      check(sigRange_q, 7'h00);
    end
    wb(1'b0, `AIAS_ADDR_ISTAT, 32'h0);
    check(rd[2], 1'b1);
    discErr <= 1'b0;
    sensValid <= 1'b1;
    wantSel <= 4'h0;
    // three cycles, scan field ignored outside reduced mode
    wb(1'b1, `AIAS_ADDR_CTRL, 32'h0000_0203);
    wait_avg(t0);
    wait_avg(t0);
    wait_avg(t1);
    check(32'(t1 - t0), 3 * CYC * 4);
    wb(1'b0, `AIAS_ADDR_MEAS, 32'h0);
    check(rd[15:0], v);
    check(sensorOk_q, 1'b1);
    check(enable_q, 1'b1);
    // enable is back, but the far side must wait for an explicit restart
    check(runOk_q, 1'b0);
    @(posedge clk_sys);
    restartReq <= 1'b1;
    @(posedge clk_sys);
    restartReq <= 1'b0;
    @(posedge clk_sys);
    check(runOk_q, 1'b1);
    // reduced scans force single-cycle blocks
    wb(1'b1, `AIAS_ADDR_CTRL, 32'h0000_0223);
    wait_avg(t0);
    wait_avg(t0);
    wait_avg(t1);
    check(32'(t1 - t0), CYC * 4);
    wb(1'b0, `AIAS_ADDR_MEAS, 32'h0);
    check(rd[15:0], v);
    give_verdict();
  end

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
endmodule // aias_top_bench
`default_nettype wire
